// file: hw/vc_arb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module vc_arb_ctrl #(
    parameter bit UPSTREAM = 1'b1
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        arb_next_i,
    output logic      [3:0]  grant_port_o,
    output logic      [2:0]  arb_scheme_o,
    output logic      [7:0]  traffic_class_map_o,
    output logic             load_busy_o
);
    typedef enum logic [1:0] {
        LD_IDLE = 2'b01,
        LD_COPY = 2'b10
    } load_state_t;

    localparam logic [7:0] ARB_CAP =
        UPSTREAM ? vc_arb_ctrl_pkg::ARB_CAP_UP : vc_arb_ctrl_pkg::ARB_CAP_DN;
    localparam logic [7:0] TBL_OFF =
        UPSTREAM ? vc_arb_ctrl_pkg::TBL_OFF_UP : vc_arb_ctrl_pkg::TBL_OFF_DN;

    // refuse a load count that the 8-bit down-counter cannot hold
    if (vc_arb_ctrl_pkg::LOAD_CYCLES < 1 ||
        vc_arb_ctrl_pkg::LOAD_CYCLES > 255) begin : g_load_chk
        $error("load cycle count out of range");
    end

    logic [7:0]  tcmap_q;
    logic [2:0]  sel_q;
    logic [31:0] tbl_q [vc_arb_ctrl_pkg::TBL_WORDS];
    logic [31:0] live_q [vc_arb_ctrl_pkg::TBL_WORDS];
    logic        tstat_q;
    load_state_t ld_q;
    logic [7:0]  ld_cnt_q;
    logic [31:0] rdata_q;
    logic [4:0]  phase_q;
    logic [3:0]  grant_q;

    logic wr_ctrl;
    logic wr_tbl;
    logic tbl_hit;
    logic [1:0] tbl_idx;
    logic uses_table;
    logic load_req;
    logic [31:0] ctrl_rd;

    assign wr_ctrl = wr_i && addr_i == vc_arb_ctrl_pkg::CTRL_OFFS;
    assign tbl_hit = addr_i >= vc_arb_ctrl_pkg::TBL_OFFS &&
                     addr_i < vc_arb_ctrl_pkg::TBL_OFFS + 12'h010;
    assign tbl_idx = addr_i[3:2];
    assign wr_tbl  = UPSTREAM && wr_i && tbl_hit;
    // scheme 1 (weighted round robin) is the one that uses the table, where ARB_CAP bit 1 is set
    assign uses_table = sel_q == 3'h1 && ARB_CAP[1];

    assign load_req = UPSTREAM && wr_ctrl &&
                      wdata_i[vc_arb_ctrl_pkg::LOAD_BIT] && uses_table;

    // traffic class map
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tcmap_q <= vc_arb_ctrl_pkg::TCMAP_RST;
        end else if (wr_ctrl) begin
            tcmap_q <= {wdata_i[7:1], 1'b1};
        end
    end

    // scheme select
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sel_q <= vc_arb_ctrl_pkg::SEL_RST;
        end else if (wr_ctrl) begin
            sel_q <= wdata_i[vc_arb_ctrl_pkg::SEL_LSB +: 3];
        end
    end

    // software-visible table storage
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < vc_arb_ctrl_pkg::TBL_WORDS; i++) begin
                tbl_q[i] <= 32'h0000_0000;
            end
        end else if (wr_tbl) begin
            tbl_q[tbl_idx] <= wdata_i;
        end
    end

    // load sequencer and live copy
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ld_q     <= LD_IDLE;
            ld_cnt_q <= 8'h00;
            for (int i = 0; i < vc_arb_ctrl_pkg::TBL_WORDS; i++) begin
                live_q[i] <= 32'h0000_0000;
            end
        end else begin
            case (ld_q)
                LD_IDLE: begin
                    if (load_req) begin
                        ld_q     <= LD_COPY;
                        ld_cnt_q <= 8'(vc_arb_ctrl_pkg::LOAD_CYCLES - 1);
                    end
                end
                LD_COPY: begin
                    if (ld_cnt_q == 8'h00) begin
                        for (int i = 0; i < vc_arb_ctrl_pkg::TBL_WORDS;
                             i++) begin
                            live_q[i] <= tbl_q[i];
                        end
                        ld_q <= LD_IDLE;
                    end else begin
                        ld_cnt_q <= ld_cnt_q - 8'h01;
                    end
                end
                default: begin
                    ld_q <= LD_IDLE;
                end
            endcase
        end
    end

    // table status flag; a new entry write beats load completion
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tstat_q <= 1'b0;
        end else if (wr_tbl) begin
            tstat_q <= 1'b1;
        end else if (ld_q == LD_COPY && ld_cnt_q == 8'h00) begin
            tstat_q <= 1'b0;
        end
    end

    // phase walker over the live copy, invalid ports skipped at once
    logic [3:0] cand;
    logic [4:0] nphase;
    logic       found;
    always_comb begin
        cand   = 4'h0;
        nphase = phase_q;
        found  = 1'b0;
        for (int k = 1; k <= vc_arb_ctrl_pkg::PHASES; k++) begin
            logic [4:0] p;
            logic [3:0] e;
            p = 5'(phase_q + 5'(k));
            e = live_q[p[4:3]][p[2:0]*4 +: 4];
            if (!found && (e == vc_arb_ctrl_pkg::PORT_A ||
                           e == vc_arb_ctrl_pkg::PORT_B ||
                           e == vc_arb_ctrl_pkg::PORT_C)) begin
                found  = 1'b1;
                cand   = e;
                nphase = p;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            phase_q <= 5'h1f;
            grant_q <= vc_arb_ctrl_pkg::PORT_A;
        end else if (arb_next_i && uses_table && found) begin
            phase_q <= nphase;
            grant_q <= cand;
        end
    end

    // control register image
    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[vc_arb_ctrl_pkg::TCMAP_LSB +: 8] = tcmap_q;
        ctrl_rd[vc_arb_ctrl_pkg::LOAD_BIT] = 1'b0;
        ctrl_rd[vc_arb_ctrl_pkg::SEL_LSB +: 3] = sel_q;
        ctrl_rd[vc_arb_ctrl_pkg::CHID_LSB +: 3] = vc_arb_ctrl_pkg::CHID_VAL;
        ctrl_rd[vc_arb_ctrl_pkg::CHEN_BIT] = vc_arb_ctrl_pkg::CHEN_VAL;
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_q <= 32'h0000_0000;
            if (addr_i == vc_arb_ctrl_pkg::CAP_OFFS) begin
                rdata_q <= {TBL_OFF, 16'h0000, ARB_CAP};
            end else if (addr_i == vc_arb_ctrl_pkg::CTRL_OFFS) begin
                rdata_q <= ctrl_rd;
            end else if (addr_i == vc_arb_ctrl_pkg::STS_OFFS) begin
                rdata_q[vc_arb_ctrl_pkg::TSTAT_BIT] <= tstat_q && UPSTREAM;
            end else if (tbl_hit && UPSTREAM) begin
                rdata_q <= tbl_q[tbl_idx];
            end
        end
    end

    assign rdata_o             = rdata_q;
    assign grant_port_o        = grant_q;
    assign arb_scheme_o        = sel_q;
    assign traffic_class_map_o = tcmap_q;
    assign load_busy_o         = ld_q == LD_COPY;

    AST_MAP_BIT0: assert property (@(posedge mclk_i) disable iff (rst_i)
        tcmap_q[0] == 1'b1) else $error("map bit zero cleared");
    AST_MAP_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_ctrl |=> tcmap_q[7:1] == $past(wdata_i[7:1]))
        else $error("map not written");
    AST_LOAD_RD0: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(rd_i) && $past(addr_i) == vc_arb_ctrl_pkg::CTRL_OFFS |->
        rdata_o[16] == 1'b0 && rdata_o[31] && rdata_o[26:24] == 3'h0 &&
        rdata_o[23:20] == 4'h0 && rdata_o[15:8] == 8'h00)
        else $error("control readback wrong");
    AST_LOAD_DONE: assert property (@(posedge mclk_i) disable iff (rst_i)
        ld_q == LD_IDLE && load_req |-> ##[1:8] ld_q == LD_IDLE &&
        live_q[0] == tbl_q[0]) else $error("load not finished");
    AST_ZERO_NOP: assert property (@(posedge mclk_i) disable iff (rst_i)
        ld_q == LD_IDLE && wr_ctrl && !wdata_i[16] |=> ld_q == LD_IDLE)
        else $error("zero write started load");
    AST_SCHEME: assert property (@(posedge mclk_i) disable iff (rst_i)
        ld_q == LD_IDLE && wr_ctrl && !uses_table |=> ld_q == LD_IDLE)
        else $error("load without table scheme");
    AST_UPSTREAM: assert property (@(posedge mclk_i) disable iff (rst_i)
        !UPSTREAM |-> ld_q == LD_IDLE && !tstat_q)
        else $error("downstream load activity");
    AST_TSTAT_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_tbl |=> tstat_q) else $error("status not set");
    AST_CAP_RD: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(rd_i) && $past(addr_i) == vc_arb_ctrl_pkg::CAP_OFFS |->
        rdata_o[31:24] == TBL_OFF && rdata_o[7:0] == ARB_CAP)
        else $error("capability readback wrong");
    AST_GRANT: assert property (@(posedge mclk_i) disable iff (rst_i)
        grant_q == 4'h0 || grant_q == 4'h2 || grant_q == 4'h4)
        else $error("invalid port granted");
    AST_TBL_DN: assert property (@(posedge mclk_i) disable iff (rst_i)
        !UPSTREAM && $past(rd_i) && $past(tbl_hit) |->
        rdata_o == 32'h0000_0000)
        else $error("downstream table readback not zero");
    AST_TSTAT_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
        ld_q == LD_COPY && ld_cnt_q == 8'h00 && !wr_tbl |=> !tstat_q)
        else $error("status not cleared after load");

    COV_LOAD: cover property (@(posedge mclk_i) disable iff (rst_i)
        load_req ##[1:8] !tstat_q);
    COV_TBL_WR: cover property (@(posedge mclk_i) disable iff (rst_i)
        wr_tbl);
    COV_GRANT: cover property (@(posedge mclk_i) disable iff (rst_i)
        arb_next_i && found && uses_table);
    // zero written to the load bit, and status falling after a load
    COV_ZERO_WRITE: cover property (@(posedge mclk_i) disable iff (rst_i)
        wr_ctrl && !wdata_i[vc_arb_ctrl_pkg::LOAD_BIT]);
    COV_STATUS_CLEAR: cover property (@(posedge mclk_i) disable iff (rst_i)
        tstat_q ##1 !tstat_q);
endmodule // vc_arb_ctrl
`default_nettype wire

// file: hw/vc_arb_ctrl_pkg.sv
`default_nettype none
package vc_arb_ctrl_pkg;
    // register offsets (byte addresses)
    localparam logic [11:0] CAP_OFFS    = 12'h210;
    localparam logic [11:0] CTRL_OFFS   = 12'h214;
    localparam logic [11:0] STS_OFFS    = 12'h218;
    localparam logic [11:0] TBL_OFFS    = 12'h220;
    localparam logic [11:0] LDCFG_OFFS  = 12'h240;
    // capability register fields
    localparam int          CAP_ARB_LSB = 0;
    localparam int          CAP_TBO_LSB = 24;
    localparam logic [7:0]  ARB_CAP_UP  = 8'h03;
    localparam logic [7:0]  ARB_CAP_DN  = 8'h01;
    localparam logic [7:0]  TBL_OFF_UP  = 8'h02;
    localparam logic [7:0]  TBL_OFF_DN  = 8'h00;
    // control register fields
    localparam int          TCMAP_LSB   = 0;
    localparam int          LOAD_BIT    = 16;
    localparam int          SEL_LSB     = 17;
    localparam int          CHID_LSB    = 24;
    localparam int          CHEN_BIT    = 31;
    localparam logic [7:0]  TCMAP_RST   = 8'hff;
    localparam logic [2:0]  SEL_RST     = 3'h0;
    localparam logic [2:0]  CHID_VAL    = 3'h0;
    localparam logic        CHEN_VAL    = 1'b1;
    // status register field
    localparam int          TSTAT_BIT   = 16;
    // table entry layout
    localparam int          ENTRY_W     = 4;
    localparam int          PHASES      = 32;
    localparam int          TBL_WORDS   = 4;
    localparam logic [3:0]  PORT_A      = 4'h0;
    localparam logic [3:0]  PORT_B      = 4'h2;
    localparam logic [3:0]  PORT_C      = 4'h4;
    // table load latency in cycles (chosen)
    localparam int          LOAD_CYCLES = 4;
endpackage
`default_nettype wire

// file: sim/vc_arb_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vc_arb_ctrl_bench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        dn_wr;
    logic        arb_next = 1'b0;
    logic [31:0] up_rdata;
    logic [31:0] dn_rdata;
    logic [31:0] up_val;
    logic [31:0] dn_val;
    logic [3:0]  up_grant;
    logic [3:0]  dn_grant;
    logic [2:0]  up_scheme;
    logic [7:0]  up_map;
    logic        up_busy;
    logic        dn_busy;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // upstream and downstream ports share one register bus
    vc_arb_ctrl #(.UPSTREAM(1'b1)) dut_u (.mclk_i(mclk), .rst_i(rst),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(up_rdata), .arb_next_i(arb_next), .grant_port_o(up_grant),
        .arb_scheme_o(up_scheme), .traffic_class_map_o(up_map),
        .load_busy_o(up_busy));
    // downstream only ever gets a control write with scheme zero
    assign dn_wr = wr && !(addr == vc_arb_ctrl_pkg::CTRL_OFFS &&
                           wdata[19:17] != 3'h0);
    vc_arb_ctrl #(.UPSTREAM(1'b0)) dn_u (.mclk_i(mclk), .rst_i(rst),
        .addr_i(addr), .wdata_i(wdata), .wr_i(dn_wr), .rd_i(rd),
        .rdata_o(dn_rdata), .arb_next_i(arb_next), .grant_port_o(dn_grant),
        .arb_scheme_o(), .traffic_class_map_o(), .load_busy_o(dn_busy));
    // clock at 50 MHz
    initial begin
        forever #10 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge mclk) rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) begin
            wr <= 1'b1;
            addr <= a;
            wdata <= d;
        end
        @(posedge mclk) wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [11:0] a);
        @(posedge mclk) begin
            rd <= 1'b1;
            addr <= a;
        end
        @(posedge mclk) rd <= 1'b0;
        #1;
        up_val = up_rdata;
        dn_val = dn_rdata;
    endtask
    task automatic pulse_next();
        @(posedge mclk) arb_next <= 1'b1;
        @(posedge mclk) arb_next <= 1'b0;
        #1;
    endtask
    // values after reset: capability on both ports, control and status on upstream only
    task automatic test_reset();
        do_reset();
        reg_rd(vc_arb_ctrl_pkg::CAP_OFFS);
        chk(up_val, {vc_arb_ctrl_pkg::TBL_OFF_UP, 16'h0000, 8'h03});
        chk(dn_val, {vc_arb_ctrl_pkg::TBL_OFF_DN, 16'h0000, 8'h01});
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h800000ff);
        chk({24'h0, up_map}, 32'h000000ff);
        reg_rd(vc_arb_ctrl_pkg::STS_OFFS);
        chk(up_val, 32'h00000000);
        $display("test_reset done");
    endtask
    // writable, fixed and reserved control bits
    task automatic test_ctrl_fields();
        reg_wr(vc_arb_ctrl_pkg::CTRL_OFFS, 32'hfff1ff00);
        chk({31'h0, up_busy}, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h80000001);
        chk(dn_val, 32'h80000001);
        reg_wr(vc_arb_ctrl_pkg::CTRL_OFFS, 32'hfff3ff00);
        chk({31'h0, up_busy}, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h80020001);
        chk(dn_val, 32'h80000001);
        chk({29'h0, up_scheme}, 32'h1);
        chk({24'h0, up_map}, 32'h00000001);
        reg_wr(vc_arb_ctrl_pkg::CTRL_OFFS, 32'h000200fe);
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h800200ff);
        $display("test_ctrl_fields done");
    endtask
    // table write, status, load and grant walk
    task automatic test_table_load();
        int n;
        reg_wr(vc_arb_ctrl_pkg::TBL_OFFS, 32'hfffffff2);
        for (int i = 1; i < 4; i++) begin
            reg_wr(vc_arb_ctrl_pkg::TBL_OFFS + 12'(4 * i), 32'hffffffff);
        end
        reg_rd(vc_arb_ctrl_pkg::STS_OFFS);
        chk({31'h0, up_val[16]}, 32'h1);
        chk(dn_val, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::TBL_OFFS);
        chk(dn_val, 32'h0);
        pulse_next();
        chk({28'h0, up_grant}, 32'h0);
        reg_wr(vc_arb_ctrl_pkg::CTRL_OFFS, 32'h000200ff);
        chk({31'h0, up_busy}, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::STS_OFFS);
        chk({31'h0, up_val[16]}, 32'h1);
        reg_wr(vc_arb_ctrl_pkg::CTRL_OFFS, 32'h000300ff);
        chk({31'h0, up_busy}, 32'h1);
        chk({31'h0, dn_busy}, 32'h0);
        n = 1;
        while (up_busy === 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(32'(n), 32'(vc_arb_ctrl_pkg::LOAD_CYCLES + 1));
        reg_rd(vc_arb_ctrl_pkg::STS_OFFS);
        chk(up_val, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h800200ff);
        pulse_next();
        chk({28'h0, up_grant}, 32'h2);
        pulse_next();
        chk({28'h0, up_grant}, 32'h2);
        chk({28'h0, dn_grant}, 32'h0);
        $display("test_table_load done");
    endtask
    // unmapped place and a second reset
    task automatic test_unmapped();
        reg_wr(12'h3fc, 32'hffffffff);
        reg_rd(12'h3fc);
        chk(up_val, 32'h0);
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h800200ff);
        do_reset();
        reg_rd(vc_arb_ctrl_pkg::CTRL_OFFS);
        chk(up_val, 32'h800000ff);
        $display("test_unmapped done");
    endtask
    // main sequence
    initial begin
        test_reset();
        test_ctrl_fields();
        test_table_load();
        test_unmapped();
        stop_test();
    end
endmodule // vc_arb_ctrl_bench
`default_nettype wire
